// ==== hw/rtcal_pkg.sv ====
package rtcal_pkg;
  localparam logic [7:0] ADDR_ALARM_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TIME_OF_DAY = 8'h04;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam int BIT_ALARM_ENABLE = 15;
  localparam int BIT_REPEAT_ROLLOVER = 14;
  localparam int BIT_PULSE_INITIAL_VALUE = 13;
  localparam int BIT_ALARM_READ_UNSAFE = 12;
  localparam int INTERVAL_LSB = 8;
  localparam int REPEAT_LSB = 0;
  localparam int CTRL_BIT_MODULE_ON = 15;
  localparam int CTRL_BIT_TIME_WRITE_UNLOCK = 3;
  localparam int CTRL_BIT_HALF_SECOND_TICK = 16;
  localparam logic [31:0] TIME_IMPL_MASK = 32'hffffff00;
  localparam logic [7:0] REPEAT_ZERO = 8'h00;
  localparam logic [7:0] REPEAT_WRAP = 8'hff;
  localparam logic [3:0] IVL_HALF_SECOND = 4'h0;
  localparam logic [3:0] IVL_SECOND = 4'h1;
  localparam logic [3:0] IVL_TEN_SECONDS = 4'h2;
  localparam logic [3:0] IVL_MINUTE = 4'h3;
  localparam logic [3:0] IVL_TEN_MINUTES = 4'h4;
  localparam logic [3:0] IVL_HOUR = 4'h5;
  localparam logic [3:0] IVL_DAY = 4'h6;
  localparam logic [3:0] IVL_WEEK = 4'h7;
  localparam logic [3:0] IVL_MONTH = 4'h8;
  localparam logic [3:0] IVL_YEAR = 4'h9;
  localparam int UNSAFE_WINDOW_RTC_CLOCKS = 32;
  localparam int RTC_CLOCK_HZ = 32768;
  localparam int HALF_SECOND_RTC_CLOCKS = RTC_CLOCK_HZ / 2;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_SECOND = 1;
  localparam int IRQ_WIDTH = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [3:0] BCD_FIVE = 4'h5;
  localparam logic [3:0] BCD_TWO = 4'h2;
  localparam logic [3:0] BCD_THREE = 4'h3;
endpackage : rtcal_pkg

// ==== hw/rtcal_top.sv ====
// Summary of operation
// - Alarm control bit 15 enables alarm generation; zero disables it.
// - Rollover set: repeat count wraps 0x00 to 0xFF; clear: stops at 0x00.
// - With alarm disabled, bit 13 is writable and sets the pulse starting level.
// - With alarm enabled, bit 13 ignores writes and reads the live pulse level.
// - Bit 12 flags that count and enable may change near half-second rollover.
// - Bit 12 clears only when over 32 RTC clocks from the next rollover.
// - Bits 11-8 select half second, second, ten seconds, minute, ten minutes, hour.
// - Codes 6-9 give day, week, month, year; 10-15 are reserved.
// - Alarm event at count zero without rollover clears the alarm enable bit.
// - Alarm control register resets only on power-on reset.
// - Time register hours BCD: tens in 31-28, units in 27-24.
// - Time register minutes BCD: tens in 23-20, units in 19-16.
// - Time register seconds BCD: tens in 15-12, units in 11-8.
// - Time register writes take effect only while the write-unlock bit is one.
// - Alarm control bits 31-16 ignore writes and read as zero.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module rtcal_top #(
  parameter int HALF_SECOND_CLOCKS = rtcal_pkg::HALF_SECOND_RTC_CLOCKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic rtc_tick,
  input wire logic day_rollover,
  input wire logic week_rollover,
  input wire logic month_rollover,
  input wire logic year_rollover,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic alarm_pulse,
  output logic irq
);
  localparam int PW = $clog2(HALF_SECOND_CLOCKS);
  localparam logic [PW-1:0] PRE_LAST = PW'(HALF_SECOND_CLOCKS - 1);
  localparam logic [PW-1:0] PRE_WINDOW = PW'(HALF_SECOND_CLOCKS - 1 - rtcal_pkg::UNSAFE_WINDOW_RTC_CLOCKS);

  // Whole state of the block in one record; bus reset spares the time base
  typedef struct packed {
    logic alarm_enable;
    logic repeat_rollover;
    logic pulse_level;
    logic [3:0] alarm_interval_select;
    logic [7:0] alarm_repeat_count;
    logic [3:0] hours_tens;
    logic [3:0] hours_units;
    logic [3:0] minutes_tens;
    logic [3:0] minutes_units;
    logic [3:0] seconds_tens;
    logic [3:0] seconds_units;
    logic half_phase;
    logic [PW-1:0] prescale;
    logic module_on;
    logic time_write_unlock;
    logic unsafe_meta;
    logic unsafe_sync;
    logic [rtcal_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [rtcal_pkg::IRQ_WIDTH-1:0] irq_enable;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rtcal_state_s;

  rtcal_state_s st_q, st_d;

  // Byte-lane merge of a register word
  function automatic logic [31:0] rtcal_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : rtcal_merge

  // Address decode shared by the write response and the read response
  function automatic logic rtcal_known(input logic [7:0] a);
    return a == rtcal_pkg::ADDR_ALARM_CONTROL || a == rtcal_pkg::ADDR_TIME_OF_DAY ||
           a == rtcal_pkg::ADDR_CLOCK_CONTROL || a == rtcal_pkg::ADDR_IRQ_STATUS ||
           a == rtcal_pkg::ADDR_IRQ_CLEAR || a == rtcal_pkg::ADDR_IRQ_ENABLE;
  endfunction : rtcal_known

  logic half_sec_tick, sec_tick, ten_sec_tick, min_tick, ten_min_tick, hour_tick;
  logic alarm_event, unsafe_raw;
  logic [31:0] alarm_word, time_word, ctrl_word, wr_val;
  logic do_write, do_read;
  logic [rtcal_pkg::IRQ_WIDTH-1:0] irq_set;

  assign half_sec_tick = st_q.module_on && rtc_tick && st_q.prescale == PRE_LAST;
  assign sec_tick = half_sec_tick && st_q.half_phase;
  assign ten_sec_tick = sec_tick && st_q.seconds_units == rtcal_pkg::BCD_NINE;
  assign min_tick = ten_sec_tick && st_q.seconds_tens == rtcal_pkg::BCD_FIVE;
  assign ten_min_tick = min_tick && st_q.minutes_units == rtcal_pkg::BCD_NINE;
  assign hour_tick = ten_min_tick && st_q.minutes_tens == rtcal_pkg::BCD_FIVE;
  // Raised once the prescaler is within the unsafe window of a rollover
  assign unsafe_raw = st_q.module_on && st_q.prescale > PRE_WINDOW;

  // Events of this cycle, kept apart so that a clear in the same cycle cannot swallow them
  assign irq_set[rtcal_pkg::IRQ_ALARM] = st_q.alarm_enable && alarm_event;
  assign irq_set[rtcal_pkg::IRQ_SECOND] = sec_tick;

  always_comb begin
    // Reserved interval codes select no event at all
    case (st_q.alarm_interval_select)
      rtcal_pkg::IVL_HALF_SECOND: alarm_event = half_sec_tick;
      rtcal_pkg::IVL_SECOND: alarm_event = sec_tick;
      rtcal_pkg::IVL_TEN_SECONDS: alarm_event = ten_sec_tick;
      rtcal_pkg::IVL_MINUTE: alarm_event = min_tick;
      rtcal_pkg::IVL_TEN_MINUTES: alarm_event = ten_min_tick;
      rtcal_pkg::IVL_HOUR: alarm_event = hour_tick;
      rtcal_pkg::IVL_DAY: alarm_event = day_rollover;
      rtcal_pkg::IVL_WEEK: alarm_event = week_rollover;
      rtcal_pkg::IVL_MONTH: alarm_event = month_rollover;
      rtcal_pkg::IVL_YEAR: alarm_event = year_rollover;
      default: alarm_event = 1'b0;
    endcase
  end

  always_comb begin
    // Register views; unimplemented bits are forced to zero
    alarm_word = '0;
    alarm_word[rtcal_pkg::BIT_ALARM_ENABLE] = st_q.alarm_enable;
    alarm_word[rtcal_pkg::BIT_REPEAT_ROLLOVER] = st_q.repeat_rollover;
    alarm_word[rtcal_pkg::BIT_PULSE_INITIAL_VALUE] = st_q.pulse_level;
    alarm_word[rtcal_pkg::BIT_ALARM_READ_UNSAFE] = st_q.unsafe_sync;
    alarm_word[rtcal_pkg::INTERVAL_LSB +: 4] = st_q.alarm_interval_select;
    alarm_word[rtcal_pkg::REPEAT_LSB +: 8] = st_q.alarm_repeat_count;
    time_word = {st_q.hours_tens, st_q.hours_units, st_q.minutes_tens, st_q.minutes_units,
                 st_q.seconds_tens, st_q.seconds_units, 8'h00};
    // Half-second phase is read-only, so software can align itself to the time base
    ctrl_word = '0;
    ctrl_word[rtcal_pkg::CTRL_BIT_MODULE_ON] = st_q.module_on;
    ctrl_word[rtcal_pkg::CTRL_BIT_TIME_WRITE_UNLOCK] = st_q.time_write_unlock;
    ctrl_word[rtcal_pkg::CTRL_BIT_HALF_SECOND_TICK] = st_q.half_phase;
  end

  // A new write waits until the last response is taken, so bresp is never overwritten
  assign do_write = st_q.aw_held && st_q.w_held && !st_q.bvalid;
  assign do_read = s_axi_arvalid && !st_q.rvalid;

  always_comb begin
    st_d = st_q;
    wr_val = '0;
    // Two-stage resync of the unsafe window into the bus view
    st_d.unsafe_meta = unsafe_raw;
    st_d.unsafe_sync = st_q.unsafe_meta;

    // Prescaler halts with the module off, which also keeps the unsafe flag low
    if (st_q.module_on && rtc_tick) begin
      st_d.prescale = (st_q.prescale == PRE_LAST) ? '0 : st_q.prescale + 1'b1;
    end
    if (half_sec_tick) begin
      st_d.half_phase = !st_q.half_phase;
    end
    // BCD time base: each digit carries into the next
    if (sec_tick) begin
      st_d.seconds_units = st_q.seconds_units + 4'h1;
      st_d.irq_status[rtcal_pkg::IRQ_SECOND] = 1'b1;
    end
    if (ten_sec_tick) begin
      st_d.seconds_units = '0;
      st_d.seconds_tens = st_q.seconds_tens + 4'h1;
    end
    if (min_tick) begin
      st_d.seconds_tens = '0;
      st_d.minutes_units = st_q.minutes_units + 4'h1;
    end
    if (ten_min_tick) begin
      st_d.minutes_units = '0;
      st_d.minutes_tens = st_q.minutes_tens + 4'h1;
    end
    // Hours wrap after 23; the digits rely on software writing valid BCD
    if (hour_tick) begin
      st_d.minutes_tens = '0;
      if (st_q.hours_tens == rtcal_pkg::BCD_TWO && st_q.hours_units == rtcal_pkg::BCD_THREE) begin
        st_d.hours_tens = '0;
        st_d.hours_units = '0;
      end else if (st_q.hours_units == rtcal_pkg::BCD_NINE) begin
        st_d.hours_units = '0;
        st_d.hours_tens = st_q.hours_tens + 4'h1;
      end else begin
        st_d.hours_units = st_q.hours_units + 4'h1;
      end
    end

    // Alarm event: toggle, count down, or once the count has run out wrap to 0xFF or stop per the rollover bit
    if (st_q.alarm_enable && alarm_event) begin
      st_d.pulse_level = !st_q.pulse_level;
      st_d.irq_status[rtcal_pkg::IRQ_ALARM] = 1'b1;
      if (st_q.alarm_repeat_count == rtcal_pkg::REPEAT_ZERO) begin
        if (st_q.repeat_rollover) begin
          st_d.alarm_repeat_count = rtcal_pkg::REPEAT_WRAP;
        end else begin
          st_d.alarm_enable = 1'b0;
        end
      end else begin
        st_d.alarm_repeat_count = st_q.alarm_repeat_count - 8'h01;
      end
    end

    // AXI4-Lite write: address and data held independently, response after both
    if (s_axi_awvalid && !st_q.aw_held) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st_q.w_held) begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = rtcal_known(st_q.aw_addr) ? rtcal_pkg::RESP_OKAY : rtcal_pkg::RESP_SLVERR;
      case (st_q.aw_addr)
        rtcal_pkg::ADDR_ALARM_CONTROL: begin
          // Software write wins over a same-cycle alarm update of these fields
          wr_val = rtcal_merge(alarm_word, st_q.w_data, st_q.w_strb);
          st_d.alarm_enable = wr_val[rtcal_pkg::BIT_ALARM_ENABLE];
          st_d.repeat_rollover = wr_val[rtcal_pkg::BIT_REPEAT_ROLLOVER];
          if (!st_q.alarm_enable) begin
            st_d.pulse_level = wr_val[rtcal_pkg::BIT_PULSE_INITIAL_VALUE];
          end
          st_d.alarm_interval_select = wr_val[rtcal_pkg::INTERVAL_LSB +: 4];
          st_d.alarm_repeat_count = wr_val[rtcal_pkg::REPEAT_LSB +: 8];
        end
        rtcal_pkg::ADDR_TIME_OF_DAY: begin
          if (st_q.time_write_unlock) begin
            wr_val = rtcal_merge(time_word, st_q.w_data, st_q.w_strb) & rtcal_pkg::TIME_IMPL_MASK;
            {st_d.hours_tens, st_d.hours_units, st_d.minutes_tens, st_d.minutes_units,
             st_d.seconds_tens, st_d.seconds_units} = wr_val[31:8];
          end
        end
        rtcal_pkg::ADDR_CLOCK_CONTROL: begin
          wr_val = rtcal_merge(ctrl_word, st_q.w_data, st_q.w_strb);
          st_d.module_on = wr_val[rtcal_pkg::CTRL_BIT_MODULE_ON];
          st_d.time_write_unlock = wr_val[rtcal_pkg::CTRL_BIT_TIME_WRITE_UNLOCK];
        end
        rtcal_pkg::ADDR_IRQ_CLEAR: begin
          // A same-cycle event survives the clear, even on a bit that was already set
          st_d.irq_status = (st_q.irq_status & ~st_q.w_data[rtcal_pkg::IRQ_WIDTH-1:0]) | irq_set;
        end
        rtcal_pkg::ADDR_IRQ_STATUS: begin
          // Status is read-only; the write still answers OKAY
        end
        rtcal_pkg::ADDR_IRQ_ENABLE: begin
          st_d.irq_enable = st_q.w_data[rtcal_pkg::IRQ_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Read path: answered the edge after the address, from the live register view
    if (do_read) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = rtcal_known(s_axi_araddr[7:0]) ? rtcal_pkg::RESP_OKAY : rtcal_pkg::RESP_SLVERR;
      case (s_axi_araddr[7:0])
        rtcal_pkg::ADDR_ALARM_CONTROL: st_d.rdata = alarm_word;
        rtcal_pkg::ADDR_TIME_OF_DAY: st_d.rdata = time_word;
        rtcal_pkg::ADDR_CLOCK_CONTROL: st_d.rdata = ctrl_word;
        rtcal_pkg::ADDR_IRQ_STATUS: st_d.rdata = 32'(st_q.irq_status);
        rtcal_pkg::ADDR_IRQ_ENABLE: st_d.rdata = 32'(st_q.irq_enable);
        rtcal_pkg::ADDR_IRQ_CLEAR: st_d.rdata = '0;
        default: st_d.rdata = '0;
      endcase
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!por_n) begin
      st_q <= '0;
    end else if (!aresetn) begin
      // Bus reset spares the alarm and time registers
      st_q <= '{alarm_enable: st_q.alarm_enable,
                repeat_rollover: st_q.repeat_rollover,
                pulse_level: st_q.pulse_level,
                alarm_interval_select: st_q.alarm_interval_select,
                alarm_repeat_count: st_q.alarm_repeat_count,
                hours_tens: st_q.hours_tens,
                hours_units: st_q.hours_units,
                minutes_tens: st_q.minutes_tens,
                minutes_units: st_q.minutes_units,
                seconds_tens: st_q.seconds_tens,
                seconds_units: st_q.seconds_units,
                half_phase: st_q.half_phase,
                prescale: st_q.prescale,
                module_on: st_q.module_on,
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Write readies come straight from the held flags, read ready from rvalid: one bubble per write buys simple logic
  assign s_axi_awready = !st_q.aw_held;
  assign s_axi_wready = !st_q.w_held;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign alarm_pulse = st_q.pulse_level;
  // Level interrupt: high until software clears the status bit or its enable
  assign irq = |(st_q.irq_status & st_q.irq_enable);
endmodule : rtcal_top
`default_nettype wire

// ==== test/rtcal_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module rtcal_properties #(
  parameter int HALF_SECOND_CLOCKS = rtcal_pkg::HALF_SECOND_RTC_CLOCKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic alarm_pulse
);
  logic [7:0] ra_q;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_q <= s_axi_araddr[7:0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !por_n);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address accepted while read pending");
  a_alarm_upper_zero: assert property (s_axi_rvalid && ra_q == 8'h00 |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("alarm control upper half not zero");
  a_time_bcd_ok: assert property (s_axi_rvalid && ra_q == 8'h04 |-> s_axi_rdata[7:0] == 8'h00 &&
    s_axi_rdata[31:28] <= 4'h2 && s_axi_rdata[27:24] <= 4'h9 && s_axi_rdata[23:20] <= 4'h5 &&
    s_axi_rdata[19:16] <= 4'h9 && s_axi_rdata[15:12] <= 4'h5 && s_axi_rdata[11:8] <= 4'h9)
    else $error("time value not in range");
  a_unmapped_err: assert property (s_axi_rvalid && ra_q > 8'h14 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_pulse_por: assert property (@(posedge aclk) disable iff (!aresetn) !por_n |=> !alarm_pulse)
    else $error("pulse not cleared by power-on reset");
endmodule : rtcal_properties
bind rtcal_top rtcal_properties #(.HALF_SECOND_CLOCKS(HALF_SECOND_CLOCKS)) u_props (.aclk, .aresetn, .por_n,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .alarm_pulse);
`default_nettype wire

// ==== test/rtc_alarm_and_time_regs_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_and_time_regs_tb;
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, rtc_tick = 1'b0;
  logic [3:0] roll = 4'h0, wstrb = 4'hf;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pulse, irq;
  logic [1:0] bresp, rresp, rs, ws;
  int mismatches = 0, n_checks = 0, cyc = 0;
  int m_en, m_ro, m_pv, m_cnt, n;
  always #10 aclk = ~aclk;
  // Small prescaler so a half second is 64 ticks
  rtcal_top #(.HALF_SECOND_CLOCKS(64)) uut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .rtc_tick(rtc_tick),
    .day_rollover(roll[0]), .week_rollover(roll[1]), .month_rollover(roll[2]), .year_rollover(roll[3]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .alarm_pulse(pulse), .irq(irq));
  task results();
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rst(input logic p);
    aresetn <= 1'b0;
    por_n <= !p;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    por_n <= 1'b1;
    @(posedge aclk);
  endtask : rst
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready && !ad) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wready && !dd) begin
        wvalid <= 1'b0;
        dd = 1'b1;
      end
    end
    do @(posedge aclk); while (!bvalid);
    ws = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task rdr(input logic [7:0] a);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rdr
  task tk(input int k);
    rtc_tick <= 1'b1;
    repeat (k) @(posedge aclk);
    rtc_tick <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : tk
  task ev();
    if (m_en != 0) begin
      m_pv = 1 - m_pv;
      if (m_cnt > 0) m_cnt--;
      else if (m_ro != 0) m_cnt = 255;
      else m_en = 0;
    end
  endtask : ev
  task cmp();
    logic [31:0] p;
    rdr(8'h00);
    p = ~rd;
    // While the flag stands, two equal counts in a row are needed
    while (rd[12] && rd[7:0] != p[7:0]) begin
      p = rd;
      rdr(8'h00);
    end
    chk(rd & 32'hffffcfff, 32'(m_en * 32768 + m_ro * 16384 + m_cnt));
    chk({31'h0, pulse}, 32'(m_pv));
  endtask : cmp
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    void'($urandom(64));
    rst(1'b1);
    rdr(8'h00);
    chk(rd, 32'h0);
    rdr(8'h04);
    chk(rd, 32'h0);
    rdr(8'h18);
    chk({30'h0, rs}, 32'h2);
    wr(8'h18, 32'h0);
    chk({30'h0, ws}, 32'h2);
    v = $urandom;
    v[15] = 1'b0;
    wr(8'h00, v);
    rdr(8'h00);
    chk(rd, v & 32'h00006fff);
    chk({31'h0, pulse}, {31'h0, v[13]});
    rst(1'b0);
    rdr(8'h00);
    chk(rd, v & 32'h00006fff);
    wstrb <= 4'h1;
    wr(8'h00, ~v);
    wstrb <= 4'hf;
    rdr(8'h00);
    chk(rd, (v & 32'h00006f00) | (~v & 32'h000000ff));
    wr(8'h04, 32'h12345600);
    rdr(8'h04);
    chk(rd, 32'h0);
    wr(8'h08, 32'h8);
    chk({30'h0, ws}, 32'h0);
    wr(8'h04, 32'h235959ab);
    rdr(8'h04);
    chk(rd, 32'h23595900);
    // Alarm fields are only written with the prescaler far from rollover
    rst(1'b1);
    wr(8'h08, 32'h8000);
    wr(8'h14, 32'h1);
    m_en = 1; m_ro = 0; m_pv = 0; m_cnt = 2;
    wr(8'h00, 32'h8002);
    wr(8'h00, 32'ha002);
    rdr(8'h00);
    chk({31'h0, rd[13]}, 32'h0);
    tk(31);
    rdr(8'h00);
    chk({31'h0, rd[12]}, 32'h0);
    tk(1);
    rdr(8'h00);
    chk({31'h0, rd[12]}, 32'h1);
    tk(32);
    ev();
    cmp();
    chk({31'h0, irq}, 32'h1);
    wr(8'h10, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(8'h14, 32'h0);
    repeat (3) begin
      tk(64);
      ev();
      cmp();
    end
    chk({31'h0, irq}, 32'h0);
    rdr(8'h0c);
    chk({31'h0, rd[0]}, 32'h1);
    wr(8'h14, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rst(1'b1);
    wr(8'h08, 32'h8000);
    m_en = 1; m_ro = 1; m_pv = 0; m_cnt = 0;
    wr(8'h00, 32'hc000);
    repeat (2) begin
      tk(64);
      ev();
      cmp();
    end
    for (int c = 0; c < 16; c++) begin
      rst(1'b1);
      wr(8'h08, 32'h8000);
      wr(8'h00, 32'h8005 | (c << 8));
      tk(128);
      roll <= (c >= 6 && c <= 9) ? 4'(1 << (c - 6)) : 4'hf;
      @(posedge aclk);
      roll <= 4'h0;
      repeat (3) @(posedge aclk);
      n = (c == 0) ? 2 : ((c == 1 || (c >= 6 && c <= 9)) ? 1 : 0);
      rdr(8'h00);
      chk({24'h0, rd[7:0]}, 32'(5 - n));
      chk({31'h0, pulse}, 32'(n & 1));
    end
    results();
  end
endmodule : rtc_alarm_and_time_regs_tb
`default_nettype wire
